// *** slc_pkg.sv ***
// constants, field layout and state type of the segment display controller
// assumes a 100 MHz register clock and AXI4-Lite word access
package slc_pkg;
    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_PORT  = 30'h0000FFA0;
    localparam logic [29:0] IDX_MAIN  = 30'h0000FFA1;
    localparam logic [29:0] IDX_SEC   = 30'h0000FFA2;
    localparam logic [29:0] IDX_TRIM  = 30'h0000FFA3;
    localparam logic [29:0] IDX_REFC  = 30'h0000FFA4;
    localparam logic [29:0] IDX_STAT  = 30'h0000FFA5;
    localparam logic [29:0] IDX_RAM_LO = 30'h0000F370;
    localparam logic [29:0] IDX_RAM_HI = 30'h0000F37F;
    // port control fields
    localparam int PC_DUTY_HI = 7;
    localparam int PC_DUTY_LO = 6;
    localparam int PC_CMX     = 5;
    localparam int PC_SGS_MSB = 3;
    // main control fields
    localparam int MC_PSW     = 6;
    localparam int MC_ACT     = 5;
    localparam int MC_DISPLAY_DATA_SELECT    = 4;
    localparam int MC_CKS_MSB = 3;
    // secondary control, reference and trim fields
    localparam int SC_WAVE_B   = 7;
    localparam int SC_CONSTV   = 5;
    localparam int SC_SPLIT    = 4;
    localparam int SC_STEP_MSB = 1;
    localparam int RF_BG_ON    = 7;
    localparam int TRIM_MSB    = 3;
    // status fields
    localparam int ST_STARTED = 0;
    localparam int ST_COM_LSB = 1;
    localparam int ST_SUPPLY  = 3;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] DUTY_STATIC  = 2'h0;
    localparam logic [1:0] DUTY_QUARTER = 2'h3;
    localparam int SEGS_PER_SGS = 4;
    localparam int NUM_SEG      = 32;
    localparam int NUM_COM      = 4;
    localparam int RAM_BYTES    = 16;
    localparam int NIBBLE       = 4;
    // base time that one common stays active, scaled by frame select
    localparam int STEP_TIME_NS  = 1000000;
    localparam int CLK_PERIOD_NS = 10;
    typedef enum logic [1:0] {SCAN_IDLE = 2'h1, SCAN_RUN = 2'h2} slc_scan_e;
    typedef struct packed {
        logic [7:0]       port;
        logic [7:0]       main;
        logic [7:0]       sec;
        logic [7:0]       trim;
        logic [7:0]       refc;
        logic [15:0][7:0] ram;
        logic             started;
        slc_scan_e        scan;
        logic [1:0]       com;
        logic [23:0]      pre;
        logic [3:0]       div;
        logic             aw_got;
        logic             w_got;
        logic [29:0]      aw_idx;
        logic [7:0]       w_data;
        logic             w_en;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic [31:0]      seg;
        logic [31:0]      seg_en;
        logic [3:0]       com_out;
        logic [3:0]       com_en;
        logic             supply;
    } slc_state_s;
endpackage : slc_pkg

// *** slc_lcd_ctrl.sv ***
// segment display controller: registers, display memory and common scan
// assumes an AXI4-Lite master on REF_CLK and a passive panel on the pins
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module slc_lcd_ctrl #(
    parameter int unsigned STEP_CYC = slc_pkg::STEP_TIME_NS / slc_pkg::CLK_PERIOD_NS
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      SEG_DATA,
    output logic [31:0]      SEG_OE,
    output logic [3:0]       COM_DATA,
    output logic [3:0]       COM_OE,
    output logic             DRIVE_SUPPLY_ON,
    output logic             WAVE_B_SEL,
    output logic [1:0]       STEPUP_CLK_SEL,
    output logic             SPLIT_RES_ON,
    output logic             CONST_V_ON,
    output logic             BANDGAP_ON,
    output logic [3:0]       DRIVE_TRIM
);
    slc_pkg::slc_state_s q;
    slc_pkg::slc_state_s d;
    logic                act;
    logic [1:0]          duty;
    logic                do_wr;

    // address classification
    function automatic logic is_ram(input logic [29:0] idx);
        is_ram = (idx >= slc_pkg::IDX_RAM_LO) && (idx <= slc_pkg::IDX_RAM_HI);
    endfunction : is_ram

    function automatic logic is_mapped(input logic [29:0] idx);
        is_mapped = is_ram(idx) || (idx >= slc_pkg::IDX_PORT && idx <= slc_pkg::IDX_STAT);
    endfunction : is_mapped

    // byte read back for one register index
    function automatic logic [7:0] rd_byte(input slc_pkg::slc_state_s s,
                                           input logic [29:0] idx);
        logic [7:0] st;
        st = 8'h00;
        st[slc_pkg::ST_STARTED] = s.started;
        st[slc_pkg::ST_COM_LSB +: 2] = s.com;
        st[slc_pkg::ST_SUPPLY] = s.supply;
        if (is_ram(idx))
            rd_byte = s.ram[idx[3:0]];
        else if (idx == slc_pkg::IDX_PORT)
            rd_byte = s.port;
        else if (idx == slc_pkg::IDX_MAIN)
            rd_byte = s.main;
        else if (idx == slc_pkg::IDX_SEC)
            rd_byte = s.sec;
        else if (idx == slc_pkg::IDX_TRIM)
            rd_byte = s.trim;
        else if (idx == slc_pkg::IDX_REFC)
            rd_byte = s.refc;
        else if (idx == slc_pkg::IDX_STAT)
            rd_byte = st;
        else
            rd_byte = 8'h00;
    endfunction : rd_byte

    // handshake outputs straight from state
    assign AWREADY = !q.aw_got && !q.bvalid;
    assign WREADY  = !q.w_got && !q.bvalid;
    assign ARREADY = !q.rvalid;
    assign act     = q.main[slc_pkg::MC_ACT];
    assign duty    = q.port[slc_pkg::PC_DUTY_HI:slc_pkg::PC_DUTY_LO];

    // next state: bus slave, registers, scan and pin drive
    always_comb
    begin
        d = q;
        do_wr = 1'b0;
        if (AWVALID && AWREADY)
        begin
            d.aw_got = 1'b1;
            d.aw_idx = AWADDR[31:2];
        end
        if (WVALID && WREADY)
        begin
            d.w_got  = 1'b1;
            d.w_data = WDATA[7:0];
            d.w_en   = WSTRB[0];
        end
        if (q.bvalid && BREADY)
            d.bvalid = 1'b0;
        // stop drops the started flag; a memory write below sets it only while running
        if (!act)
            d.started = 1'b0;
        if (d.aw_got && d.w_got && !q.bvalid)
        begin
            do_wr    = 1'b1;
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = is_mapped(d.aw_idx) ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
            if (d.w_en)
            begin
                if (is_ram(d.aw_idx))
                begin
                    d.ram[d.aw_idx[3:0]] = d.w_data;
                    if (act)
                        d.started = 1'b1;
                end
                else if (d.aw_idx == slc_pkg::IDX_PORT)
                    d.port = d.w_data;
                else if (d.aw_idx == slc_pkg::IDX_MAIN)
                    d.main = d.w_data;
                else if (d.aw_idx == slc_pkg::IDX_SEC)
                    d.sec = d.w_data;
                else if (d.aw_idx == slc_pkg::IDX_TRIM)
                    d.trim = d.w_data;
                else if (d.aw_idx == slc_pkg::IDX_REFC)
                    d.refc = d.w_data;
            end
        end
        if (q.rvalid && RREADY)
            d.rvalid = 1'b0;
        if (ARVALID && ARREADY)
        begin
            d.rvalid = 1'b1;
            d.rdata  = {24'h000000, rd_byte(q, ARADDR[31:2])};
            d.rresp  = is_mapped(ARADDR[31:2]) ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
        end
        // common scan: prescaler, frame divider, common index
        case (q.scan)
            slc_pkg::SCAN_IDLE:
            begin
                d.pre = 24'h000000;
                d.div = 4'h0;
                d.com = 2'h0;
                if (act)
                    d.scan = slc_pkg::SCAN_RUN;
            end
            slc_pkg::SCAN_RUN:
            begin
                if (!act)
                    d.scan = slc_pkg::SCAN_IDLE;
                else if (q.pre == 24'(STEP_CYC - 1))
                begin
                    d.pre = 24'h000000;
                    if (q.div == q.main[slc_pkg::MC_CKS_MSB:0])
                    begin
                        d.div = 4'h0;
                        d.com = (q.com >= duty) ? 2'h0 : q.com + 2'h1;
                    end
                    else
                        d.div = q.div + 4'h1;
                end
                else
                    d.pre = q.pre + 24'h000001;
            end
            default:
                d.scan = slc_pkg::SCAN_IDLE;
        endcase
        // segment pins: enable from select field, level from memory bit
        for (int s = 0; s < slc_pkg::NUM_SEG; s++)
        begin
            d.seg_en[s] = s < int'(q.port[slc_pkg::PC_SGS_MSB:0]) * slc_pkg::SEGS_PER_SGS;
            d.seg[s] = d.seg_en[s] && act && q.started && q.main[slc_pkg::MC_DISPLAY_DATA_SELECT]
                && q.ram[s / 2][(s % 2) * slc_pkg::NIBBLE + int'(q.com)];
        end
        // common pins: own phase, or a copy of a used common when parallel
        for (int p = 0; p < slc_pkg::NUM_COM; p++)
        begin
            d.com_out[p] = act && (int'(q.com) == p % (int'(duty) + 1));
            d.com_en[p] = act && ((p <= int'(duty)) || (duty != slc_pkg::DUTY_QUARTER
                && q.port[slc_pkg::PC_CMX]));
        end
        d.supply = act && q.main[slc_pkg::MC_PSW];
    end

    // single state register
    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            q        <= '0;
            q.port   <= slc_pkg::RST_REG;
            q.main   <= slc_pkg::RST_REG;
            q.sec    <= slc_pkg::RST_REG;
            q.trim   <= slc_pkg::RST_REG;
            q.refc   <= slc_pkg::RST_REG;
            q.scan   <= slc_pkg::SCAN_IDLE;
        end
        else
            q <= d;
    end

    // outputs
    assign BVALID          = q.bvalid;
    assign BRESP           = q.bresp;
    assign RVALID          = q.rvalid;
    assign RDATA           = q.rdata;
    assign RRESP           = q.rresp;
    assign SEG_DATA        = q.seg;
    assign SEG_OE          = q.seg_en;
    assign COM_DATA        = q.com_out;
    assign COM_OE          = q.com_en;
    assign DRIVE_SUPPLY_ON = q.supply;
    assign WAVE_B_SEL      = q.sec[slc_pkg::SC_WAVE_B];
    assign STEPUP_CLK_SEL  = q.sec[slc_pkg::SC_STEP_MSB:0];
    assign SPLIT_RES_ON    = q.sec[slc_pkg::SC_SPLIT];
    assign CONST_V_ON      = q.sec[slc_pkg::SC_CONSTV];
    assign BANDGAP_ON      = q.refc[slc_pkg::RF_BG_ON];
    assign DRIVE_TRIM      = q.trim[slc_pkg::TRIM_MSB:0];

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_stop_supply: assert property (!act |=> !DRIVE_SUPPLY_ON && COM_OE == 4'h0)
        else $error("supply or commons active while stopped");
    a_blank_data: assert property (!q.main[slc_pkg::MC_DISPLAY_DATA_SELECT] |=> SEG_DATA == 32'h0)
        else $error("segments not blank");
    a_quarter_com: assert property (
        act && duty == slc_pkg::DUTY_QUARTER |=> COM_OE == 4'hF)
        else $error("quarter duty commons not all driven");
    a_static_com: assert property (
        act && duty == slc_pkg::DUTY_STATIC && !q.port[slc_pkg::PC_CMX] |=> COM_OE == 4'h1)
        else $error("static duty common enable wrong");
    a_parallel_com: assert property (
        act && duty == slc_pkg::DUTY_STATIC && q.port[slc_pkg::PC_CMX] |=> COM_OE == 4'hF)
        else $error("parallel commons not driven");
    a_seg_select: assert property (
        q.port[slc_pkg::PC_SGS_MSB:0] == 4'h4 |=> SEG_OE == 32'h0000FFFF)
        else $error("segment enable pattern wrong");
    a_ram_start: assert property (do_wr && d.w_en && is_ram(d.aw_idx) && act
        |=> q.started)
        else $error("display memory write did not start display");
    a_odd_nibble: assert property (
        act && q.started && q.main[slc_pkg::MC_DISPLAY_DATA_SELECT] && q.port[slc_pkg::PC_SGS_MSB:0] == 4'h4
        |=> SEG_DATA[0] == $past(q.ram[0][q.com])
        && SEG_DATA[1] == $past(q.ram[0][slc_pkg::NIBBLE + q.com]))
        else $error("segment data does not follow memory");
    a_com_wrap: assert property (q.scan == slc_pkg::SCAN_RUN && act
        && q.pre == 24'(STEP_CYC - 1) && q.div == q.main[slc_pkg::MC_CKS_MSB:0]
        && q.com >= duty
        |=> q.com == 2'h0)
        else $error("common scan did not wrap");
    a_port_read: assert property (ARVALID && ARREADY && ARADDR[31:2] == slc_pkg::IDX_PORT
        |=> RVALID && RDATA == {24'h000000, $past(q.port)})
        else $error("port control read back wrong");
    a_write_answer: assert property (do_wr |=> BVALID)
        else $error("write response missing");

    // scan sequence, stopped pins, supply and empty segment select
    a_com_first: assert property (act |=> COM_DATA[0] == ($past(q.com) == 2'h0))
        else $error("first common phase wrong");
    a_quarter_phase: assert property (act && duty == slc_pkg::DUTY_QUARTER
        |=> $onehot(COM_DATA))
        else $error("quarter duty phases not one at a time");
    a_com_hold: assert property (q.scan == slc_pkg::SCAN_RUN && act
        && q.pre != 24'(STEP_CYC - 1) |=> $stable(q.com))
        else $error("common moved inside a step");
    a_com_advance: assert property (q.scan == slc_pkg::SCAN_RUN && act
        && q.pre == 24'(STEP_CYC - 1) && q.div == q.main[slc_pkg::MC_CKS_MSB:0]
        && q.com < duty |=> q.com == $past(q.com) + 2'h1)
        else $error("common did not advance");
    a_stop_pins: assert property (!act |=> COM_DATA == 4'h0 && SEG_DATA == 32'h0)
        else $error("pins active while stopped");
    a_stop_started: assert property (!act |=> !q.started)
        else $error("started flag kept while stopped");
    a_supply_on: assert property (act && q.main[slc_pkg::MC_PSW] |=> DRIVE_SUPPLY_ON)
        else $error("drive supply not switched on");
    a_seg_none: assert property (
        q.port[slc_pkg::PC_SGS_MSB:0] == 4'h0 |=> SEG_OE == 32'h0)
        else $error("segment pins enabled with empty select");
endmodule : slc_lcd_ctrl
`default_nettype wire

// *** slc_panel_model.sv ***
// passive segment panel model: records which segment-common crossings lit up
// assumes logical phase levels on the segment and common pins, one clock domain
`timescale 1ns/1ps
`default_nettype none
module slc_panel_model (
    input  wire logic             clk,
    input  wire logic             wipe,
    input  wire logic [31:0]      seg,
    input  wire logic [3:0]       com,
    output logic      [3:0][31:0] lit
);
    // a crossing lights when its common is in phase and its segment is on
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < 4; c++)
        begin
            if (wipe)
                lit[c] <= 32'h0;
            else if (com[c])
                lit[c] <= lit[c] | seg;
        end
    end
endmodule : slc_panel_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench: register bus tasks drive the controller, a panel model watches the pins
// assumes slc_pkg and slc_lcd_ctrl compiled first; short scan step for quick frames
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic             clk, rst, wipe, awvalid, wvalid, arvalid;
    logic [31:0]      awaddr, wdata, araddr, d;
    logic             awready, wready, bvalid, arready, rvalid;
    logic             drive_on, wave_b, split_on, constv_on, bg_on;
    logic [1:0]       bresp, rresp, step_sel, r;
    logic [31:0]      rdata, seg_d, seg_oe;
    logic [3:0]       com_d, com_oe, trim, e, wstrb;
    logic [3:0][31:0] lit;
    logic [15:0]      exp_lit;
    int               n_fail, total_checks;

    slc_lcd_ctrl #(.STEP_CYC(4)) slc_lcd_ctrl_inst (
        .REF_CLK(clk), .RESET(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
        .SEG_DATA(seg_d), .SEG_OE(seg_oe), .COM_DATA(com_d), .COM_OE(com_oe),
        .DRIVE_SUPPLY_ON(drive_on), .WAVE_B_SEL(wave_b), .STEPUP_CLK_SEL(step_sel),
        .SPLIT_RES_ON(split_on), .CONST_V_ON(constv_on), .BANDGAP_ON(bg_on),
        .DRIVE_TRIM(trim));
    slc_panel_model slc_panel_model_inst (.clk(clk), .wipe(wipe), .seg(seg_d), .com(com_d),
        .lit(lit));

    // compare one value and count it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // report the counts and end the run
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // write one byte: address and data offered together, each released when taken
    task automatic wr(input logic [29:0] idx, input logic [7:0] v, output logic [1:0] rs);
        int   n;
        logic aw_p;
        logic w_p;
        n = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        rs = 2'h0;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // look only after an edge, so a response left from the last write is never taken
        do
        begin
            @(posedge clk);
            n++;
            if (aw_p && awready)
            begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready)
            begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
            rs = bresp;
        end
        while (n < 50 && !(bvalid && !aw_p && !w_p));
        if (n >= 50)
        begin
            n_fail++;
            close_out();
        end
    endtask : wr

    // read one word, data taken at the edge where the answer is seen
    task automatic rd(input logic [29:0] idx, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            v = rdata;
            rs = rresp;
        end
        while (n < 50 && !(rvalid && !arvalid));
        if (n >= 50)
        begin
            n_fail++;
            close_out();
        end
    endtask : rd

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask : ticks

    // clean the panel record and let a few frames pass
    task automatic frames;
        wipe <= 1'b1;
        ticks(1);
        wipe <= 1'b0;
        ticks(40);
    endtask : frames

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial
    begin
        rst = 1'b1; wipe = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
        awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0; n_fail = 0; total_checks = 0;
        wstrb = 4'hF;
        exp_lit = 16'h2753;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(slc_pkg::IDX_PORT, d, r);
        check("port reset", d, 32'h0);
        wr(slc_pkg::IDX_PORT, 8'hE4, r);
        rd(slc_pkg::IDX_PORT, d, r);
        check("port readback", d, 32'hE4);
        check("read okay", {30'h0, r}, {30'h0, slc_pkg::RESP_OKAY});
        // a write with its byte strobe off must leave the register alone
        wstrb <= 4'h0;
        wr(slc_pkg::IDX_PORT, 8'h00, r);
        wstrb <= 4'hF;
        check("strobe off okay", {30'h0, r}, {30'h0, slc_pkg::RESP_OKAY});
        rd(slc_pkg::IDX_PORT, d, r);
        check("strobe off kept", d, 32'hE4);
        rd(slc_pkg::IDX_STAT, d, r);
        check("started early", d & 32'h1, 32'h0);
        wr(slc_pkg::IDX_MAIN, 8'h70, r);
        check("write okay", {30'h0, r}, {30'h0, slc_pkg::RESP_OKAY});
        wr(slc_pkg::IDX_SEC, 8'hB3, r);
        wr(slc_pkg::IDX_REFC, 8'h80, r);
        wr(slc_pkg::IDX_TRIM, 8'h0A, r);
        ticks(3);
        check("trim pins", {28'h0, trim}, 32'hA);
        check("supply on", {31'h0, drive_on}, 32'h1);
        check("secondary pins", {27'h0, wave_b, constv_on, split_on, step_sel}, 32'h1F);
        check("bandgap", {31'h0, bg_on}, 32'h1);
        check("quarter commons", {28'h0, com_oe}, 32'hF);
        check("segment enables", seg_oe, 32'h0000FFFF);
        // display data goes in only after the setup above
        wr(slc_pkg::IDX_RAM_LO, 8'hD7, r);
        wr(slc_pkg::IDX_RAM_LO + 30'h1, 8'h06, r);
        rd(slc_pkg::IDX_RAM_LO, d, r);
        check("memory readback", d, 32'hD7);
        rd(slc_pkg::IDX_STAT, d, r);
        check("started", d & 32'h1, 32'h1);
        frames();
        for (int c = 0; c < 4; c++)
            check("lit crossings", lit[c], {28'h0, exp_lit[c*4 +: 4]});
        wr(slc_pkg::IDX_MAIN, 8'h60, r);
        frames();
        check("blank", lit[0] | lit[1] | lit[2] | lit[3], 32'h0);
        for (int dt = 0; dt < 3; dt++)
            for (int p = 0; p < 2; p++)
            begin
                for (int q = 0; q < 4; q++)
                    e[q] = (q <= dt) || (p == 1);
                wr(slc_pkg::IDX_PORT, {dt[1:0], p[0], 5'h04}, r);
                ticks(3);
                check("duty commons", {28'h0, com_oe}, {28'h0, e});
            end
        wr(slc_pkg::IDX_MAIN, 8'h40, r);
        ticks(3);
        check("stopped supply", {31'h0, drive_on}, 32'h0);
        check("stopped commons", {28'h0, com_oe}, 32'h0);
        rd(slc_pkg::IDX_RAM_LO, d, r);
        check("memory kept", d, 32'hD7);
        rd(slc_pkg::IDX_STAT, d, r);
        check("stopped status", d & 32'hF, 32'h0);
        rd(30'h0, d, r);
        check("unmapped read", {30'h0, r}, {30'h0, slc_pkg::RESP_SLVERR});
        wr(30'h1, 8'h5A, r);
        check("unmapped write", {30'h0, r}, {30'h0, slc_pkg::RESP_SLVERR});
        close_out();
    end
endmodule : testbench
`default_nettype wire
